// >>> blf_backlight_ctrl.sv
// Backlight fade sequencer, sleep, shutdown and regulator gating with an AHB-Lite slave
`default_nettype none
////////////////////////////////////////////////////////////////////////////////
module blf_backlight_ctrl
  import blf_pkg::*;
#(
  parameter int SHUTDOWN_US = 1000,
  parameter int STARTUP_US = 100,
  parameter int FADE_TICK_US = 1000
)(
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic [31:0] hrdata,
  output logic hresp,
  input wire logic single_wire_pin,
  input wire logic regulator_one_enable_pin,
  input wire logic regulator_two_enable_pin,
  input wire logic output_overvoltage_limit,
  input wire logic overtemp_shutdown,
  input wire logic overtemp_cooled,
  input wire logic [SINKS-1:0] open_fault,
  output logic [LVL_W-1:0] main_code,
  output logic [LVL_W-1:0] sub_code,
  output logic [SINKS-1:0] sink_on,
  output logic low_iq_bias,
  output logic regulator_one_on,
  output logic regulator_two_on,
  output logic [4:0] regulator_one_vsel,
  output logic [4:0] regulator_two_vsel,
  output logic cp_switch_en,
  output logic clk_run,
  output logic device_enabled
);
  localparam int SD_CYC = SHUTDOWN_US * CLK_MHZ;
  localparam int SU_CYC = STARTUP_US * CLK_MHZ;
  localparam int TICK_CYC = FADE_TICK_US * CLK_MHZ;
  localparam int CW = $clog2((SD_CYC > SU_CYC ? SD_CYC : SU_CYC) + 2);
  localparam int TW = $clog2(TICK_CYC + 1);

  //////////////////////////////////////////////////////////////////////////////
  // Wire monitor: start-up and shutdown timing
  logic [CW-1:0] hi_cnt_reg, hi_cnt_next, lo_cnt_reg, lo_cnt_next;
  logic en_reg, en_next;

  always_comb
  begin
    hi_cnt_next = hi_cnt_reg;
    lo_cnt_next = lo_cnt_reg;
    en_next = en_reg;
    if (single_wire_pin)
    begin
      lo_cnt_next = '0;
      if (hi_cnt_reg != CW'(SU_CYC))
        hi_cnt_next = hi_cnt_reg + 1'b1;
      else
        en_next = 1'b1;
    end
    else
    begin
      hi_cnt_next = '0;
      if (lo_cnt_reg != CW'(SD_CYC))
        lo_cnt_next = lo_cnt_reg + 1'b1;
      if (lo_cnt_next == CW'(SD_CYC))
        en_next = 1'b0;
    end
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      hi_cnt_reg <= '0;
      lo_cnt_reg <= '0;
      en_reg <= 1'b0;
    end
    else
    begin
      hi_cnt_reg <= hi_cnt_next;
      lo_cnt_reg <= lo_cnt_next;
      en_reg <= en_next;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Configuration, fade sequencer and output gating
  logic [LVL_W-1:0] main_tgt_reg, main_tgt_next, sub_tgt_reg, sub_tgt_next;
  logic [LVL_W-1:0] main_next, sub_next;
  logic [SINKS-1:0] sink_en_reg, sink_en_next, fault_reg, fault_next;
  logic [SINKS-1:0] sink_on_next, grp_cur, grp_any;
  blf_fade_t fade_reg, fade_next;
  blf_ldo_t regulator_one_reg, regulator_one_next, regulator_two_reg, regulator_two_next;
  logic [TW-1:0] tick_cnt_reg, tick_cnt_next;
  logic [3:0] rate_cnt_reg, rate_cnt_next;
  logic wr_pend_reg, wr_pend_next;
  logic [3:0] wr_idx_reg, wr_idx_next;
  logic [31:0] hrdata_next;
  logic ot_reg, ot_next, sleep_reg, sleep_next, low_iq_next, busy;
  logic reg1_next, reg2_next, cp_next, tick, step, addr_ok;
  logic [LVL_W-1:0] wlvl;
  logic [31:0] stat_word;

  always_comb
  begin
    main_tgt_next = main_tgt_reg;
    sub_tgt_next = sub_tgt_reg;
    sink_en_next = sink_en_reg;
    fade_next = fade_reg;
    regulator_one_next = regulator_one_reg;
    regulator_two_next = regulator_two_reg;
    fault_next = fault_reg | (sink_on & open_fault);
    wlvl = blf_clamp(hwdata[LVL_W-1:0]);
    // Writes land in the data phase; ignored while the device is shut down
    if (wr_pend_reg && en_reg)
    begin
      case (wr_idx_reg)
        IDX_MAIN: main_tgt_next = wlvl;
        IDX_SUB: sub_tgt_next = wlvl;
        IDX_EN: sink_en_next = hwdata[SINKS-1:0];
        IDX_FADE: fade_next = '{en: hwdata[EN_BIT], rate: hwdata[3:0]};
        IDX_REG1: regulator_one_next = '{en: hwdata[EN_BIT], vsel: hwdata[4:0]};
        IDX_REG2: regulator_two_next = '{en: hwdata[EN_BIT], vsel: hwdata[4:0]};
        // A new fault in the same cycle survives the clear
        IDX_FAULT: fault_next = (fault_reg & ~hwdata[SINKS-1:0]) | (sink_on & open_fault);
        default: ;
      endcase
    end
    // Thermal shutdown touches no register here, so the setup survives it
    ot_next = overtemp_shutdown | (ot_reg & ~overtemp_cooled);
    // Fade timing: prescaled tick, then a countdown reloaded from the rate field
    tick = (tick_cnt_reg == TW'(TICK_CYC - 1));
    tick_cnt_next = tick_cnt_reg;
    // Sleep gates the internal clock, so the prescaler holds
    if (!sleep_reg)
      tick_cnt_next = tick ? '0 : tick_cnt_reg + 1'b1;
    step = 1'b0;
    rate_cnt_next = rate_cnt_reg;
    if (rate_cnt_reg > fade_next.rate)
      rate_cnt_next = fade_next.rate;
    else if (tick && !sleep_reg)
    begin
      if (rate_cnt_reg == 4'h0)
      begin
        step = 1'b1;
        rate_cnt_next = fade_next.rate;
      end
      else
        rate_cnt_next = rate_cnt_reg - 4'h1;
    end
    // Both groups share one sequencer; the walk always starts from the
    // present code, so a retarget simply changes the goal
    main_next = main_code;
    sub_next = sub_code;
    if (!fade_next.en)
    begin
      main_next = main_tgt_next;
      sub_next = sub_tgt_next;
    end
    else if (step)
    begin
      main_next = blf_step(main_code, main_tgt_next);
      sub_next = blf_step(sub_code, sub_tgt_next);
    end
    if (!en_next)
    begin
      main_tgt_next = LVL_ZERO;
      sub_tgt_next = LVL_ZERO;
      sink_en_next = RST_SINK_EN;
      fade_next = RST_FADE;
      regulator_one_next = RST_LDO;
      regulator_two_next = RST_LDO;
      fault_next = '0;
      main_next = LVL_ZERO;
      sub_next = LVL_ZERO;
      rate_cnt_next = 4'h0;
    end
    busy = (main_next != main_tgt_next) || (sub_next != sub_tgt_next);
    grp_cur = (SUB_MASK & {SINKS{sub_next != LVL_ZERO}}) |
              (~SUB_MASK & {SINKS{main_next != LVL_ZERO}});
    grp_any = grp_cur | (SUB_MASK & {SINKS{sub_tgt_next != LVL_ZERO}}) |
              (~SUB_MASK & {SINKS{main_tgt_next != LVL_ZERO}});
    sink_on_next = sink_en_next & ~fault_next & grp_cur & {SINKS{en_next & ~ot_next}};
    sleep_next = ((sink_en_next & ~fault_next & grp_any) == '0);
    low_iq_next = (main_next <= LOWIQ_CODE) && (sub_next <= LOWIQ_CODE);
    // Regulators ignore sleep; only pin, enable bit, heat and shutdown gate them
    reg1_next = regulator_one_enable_pin & regulator_one_next.en & en_next & ~ot_next;
    reg2_next = regulator_two_enable_pin & regulator_two_next.en & en_next & ~ot_next;
    cp_next = en_next & ~sleep_next & ~ot_next & ~output_overvoltage_limit;
    // Address phase; read data comes from next values so a write is seen at once
    addr_ok = (haddr[31:IDX_MSB+1] == '0);
    wr_pend_next = hsel && hready && (htrans == HTRANS_NONSEQ) && hwrite;
    wr_idx_next = haddr[IDX_MSB:IDX_LSB];
    stat_word = '0;
    stat_word[ST_DEV] = en_next;
    stat_word[ST_SLEEP] = sleep_next;
    stat_word[ST_OT] = ot_next;
    stat_word[ST_BUSY] = busy;
    stat_word[ST_LOWIQ] = low_iq_next;
    hrdata_next = hrdata;
    if (hsel && hready && (htrans == HTRANS_NONSEQ) && !hwrite)
    begin
      hrdata_next = '0;
      if (addr_ok)
      begin
        case (haddr[IDX_MSB:IDX_LSB])
          IDX_MAIN: hrdata_next[LVL_W-1:0] = main_tgt_next;
          IDX_SUB: hrdata_next[LVL_W-1:0] = sub_tgt_next;
          IDX_EN: hrdata_next[SINKS-1:0] = sink_en_next;
          IDX_FADE: hrdata_next[EN_BIT:0] = {fade_next.en, 1'b0, fade_next.rate};
          IDX_REG1: hrdata_next[EN_BIT:0] = regulator_one_next;
          IDX_REG2: hrdata_next[EN_BIT:0] = regulator_two_next;
          IDX_STAT: hrdata_next = stat_word;
          IDX_FAULT: hrdata_next[SINKS-1:0] = fault_next;
          default: hrdata_next = '0;
        endcase
      end
    end
    if (!addr_ok)
      wr_pend_next = 1'b0;
  end

  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      main_tgt_reg <= LVL_ZERO;
      sub_tgt_reg <= LVL_ZERO;
      sink_en_reg <= RST_SINK_EN;
      fade_reg <= RST_FADE;
      regulator_one_reg <= RST_LDO;
      regulator_two_reg <= RST_LDO;
      fault_reg <= '0;
      ot_reg <= 1'b0;
      sleep_reg <= 1'b1;
      tick_cnt_reg <= '0;
      rate_cnt_reg <= 4'h0;
      wr_pend_reg <= 1'b0;
      wr_idx_reg <= 4'h0;
      main_code <= LVL_ZERO;
      sub_code <= LVL_ZERO;
      sink_on <= '0;
      low_iq_bias <= 1'b1;
      regulator_one_on <= 1'b0;
      regulator_two_on <= 1'b0;
      regulator_one_vsel <= RST_LDO.vsel;
      regulator_two_vsel <= RST_LDO.vsel;
      cp_switch_en <= 1'b0;
      clk_run <= 1'b0;
      device_enabled <= 1'b0;
      hrdata <= '0;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
    else
    begin
      main_tgt_reg <= main_tgt_next;
      sub_tgt_reg <= sub_tgt_next;
      sink_en_reg <= sink_en_next;
      fade_reg <= fade_next;
      regulator_one_reg <= regulator_one_next;
      regulator_two_reg <= regulator_two_next;
      fault_reg <= fault_next;
      ot_reg <= ot_next;
      sleep_reg <= sleep_next;
      tick_cnt_reg <= tick_cnt_next;
      rate_cnt_reg <= rate_cnt_next;
      wr_pend_reg <= wr_pend_next;
      wr_idx_reg <= wr_idx_next;
      main_code <= main_next;
      sub_code <= sub_next;
      sink_on <= sink_on_next;
      low_iq_bias <= low_iq_next;
      regulator_one_on <= reg1_next;
      regulator_two_on <= reg2_next;
      regulator_one_vsel <= regulator_one_next.vsel;
      regulator_two_vsel <= regulator_two_next.vsel;
      cp_switch_en <= cp_next;
      clk_run <= en_next & ~sleep_next;
      device_enabled <= en_next;
      hrdata <= hrdata_next;
      hreadyout <= 1'b1;
      hresp <= 1'b0;
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking blf_cb @(posedge clk);
  endclocking
  default disable iff (rst);
  a_lowiq_bias_level: assert property (
    (main_code <= LOWIQ_CODE && sub_code <= LOWIQ_CODE) == low_iq_bias)
    else $error("low quiescent bias does not match sink codes");
  a_fade_single_step: assert property (
    fade_reg.en && $past(fade_reg.en) && device_enabled && $past(device_enabled) &&
    $changed(main_code) |->
    (main_code == $past(main_code) + LVL_ONE) || (main_code + LVL_ONE == $past(main_code)))
    else $error("fade moved main code by more than one step");
  a_fade_goes_up: assert property (
    fade_reg.en && device_enabled && main_code < main_tgt_reg ##1
    fade_reg.en && device_enabled && $stable(main_tgt_reg) |->
    main_code >= $past(main_code))
    else $error("upward fade moved down");
  a_no_fade_direct: assert property (
    !fade_reg.en |-> main_code == main_tgt_reg && sub_code == sub_tgt_reg)
    else $error("code differs from target with fade off");
  a_reg1_pin_gate: assert property (
    !regulator_one_enable_pin |=> !regulator_one_on)
    else $error("regulator one on with its pin low");
  a_reg2_pin_gate: assert property (
    !regulator_two_enable_pin |=> !regulator_two_on)
    else $error("regulator two on with its pin low");
  a_shutdown_defaults: assert property (
    $fell(device_enabled) |-> sink_en_reg == RST_SINK_EN && fade_reg == RST_FADE &&
    regulator_one_reg == RST_LDO && main_tgt_reg == LVL_ZERO && sink_on == '0)
    else $error("configuration not defaulted at shutdown");
  a_sleep_pump_off: assert property (
    sleep_reg |-> !cp_switch_en && !clk_run)
    else $error("pump or clock running in sleep");
  a_ovp_stops_pump: assert property (
    output_overvoltage_limit |=> !cp_switch_en)
    else $error("pump still switching under overvoltage");
  a_ot_outputs_off: assert property (
    overtemp_shutdown |=> sink_on == '0 && !regulator_one_on && !regulator_two_on &&
    !cp_switch_en [*2])
    else $error("outputs active during thermal shutdown");
  a_fault_sink_off: assert property (
    (sink_on & open_fault) != '0 |=> (sink_on & $past(sink_on & open_fault)) == '0)
    else $error("open-circuit sink not disabled");
  c_fade_down: cover property (fade_reg.en && main_code == LVL_MAX ##[1:1000]
    main_code == LVL_MAX - LVL_ONE);
  c_ot_trip: cover property ($rose(ot_reg) ##[1:50] $fell(ot_reg));
  c_shutdown: cover property ($fell(device_enabled) ##[1:1000] $rose(device_enabled));
  c_fault: cover property ($rose(fault_reg != '0));
endmodule : blf_backlight_ctrl
`default_nettype wire

// >>> blf_pkg.sv
// Shared constants, register layout and types of the backlight fade controller
`default_nettype none
package blf_pkg;
  localparam int CLK_MHZ = 100;
  localparam int SINKS = 4;
  localparam int LVL_W = 5;
  localparam logic [LVL_W-1:0] LVL_ZERO = 5'h00;
  localparam logic [LVL_W-1:0] LVL_ONE = 5'h01;
  localparam logic [LVL_W-1:0] LVL_MAX = 5'h1c;
  localparam logic [LVL_W-1:0] LOWIQ_CODE = 5'h08;
  localparam logic [SINKS-1:0] SUB_MASK = 4'h8;
  localparam logic [3:0] IDX_MAIN = 4'h0;
  localparam logic [3:0] IDX_EN = 4'h1;
  localparam logic [3:0] IDX_SUB = 4'h2;
  localparam logic [3:0] IDX_FADE = 4'h4;
  localparam logic [3:0] IDX_REG1 = 4'h5;
  localparam logic [3:0] IDX_REG2 = 4'h6;
  localparam logic [3:0] IDX_STAT = 4'h7;
  localparam logic [3:0] IDX_FAULT = 4'h8;
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 5;
  localparam int EN_BIT = 5;
  localparam int ST_DEV = 0;
  localparam int ST_SLEEP = 1;
  localparam int ST_OT = 2;
  localparam int ST_BUSY = 3;
  localparam int ST_LOWIQ = 4;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  localparam logic [SINKS-1:0] RST_SINK_EN = 4'h0;

  typedef struct packed {
    logic en;
    logic [3:0] rate;
  } blf_fade_t;

  typedef struct packed {
    logic en;
    logic [4:0] vsel;
  } blf_ldo_t;

  localparam blf_fade_t RST_FADE = '{en: 1'b0, rate: 4'h0};
  localparam blf_ldo_t RST_LDO = '{en: 1'b0, vsel: 5'h00};

  function automatic logic [LVL_W-1:0] blf_clamp(input logic [LVL_W-1:0] v);
    blf_clamp = (v > LVL_MAX) ? LVL_MAX : v;
  endfunction : blf_clamp

  function automatic logic [LVL_W-1:0] blf_step(input logic [LVL_W-1:0] cur,
                                                input logic [LVL_W-1:0] tgt);
    if (cur < tgt)
      blf_step = cur + LVL_ONE;
    else if (cur > tgt)
      blf_step = cur - LVL_ONE;
    else
      blf_step = cur;
  endfunction : blf_step
endpackage : blf_pkg
`default_nettype wire

// >>> blf_host_model.sv
// Host side of the single-wire pin: holds it high to start the device, low to shut it down
`default_nettype none
module blf_host_model
(
  input wire logic clk,
  input wire logic hold_low,
  output logic single_wire_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  // Push-pull host output, changed just after the clock edge like any synchronous driver
  always_ff @(posedge clk)
  begin
    single_wire_pin <= !hold_low;
  end
endmodule : blf_host_model
`default_nettype wire

// >>> backlight_fade_power_control_tb.sv
// Self-checking bench of the backlight fade controller
`default_nettype none
module backlight_fade_power_control_tb;
  timeunit 1ns;
  timeprecision 1ps;
  import blf_pkg::*;
  localparam int TICK = CLK_MHZ;
  logic clk = 1'b0, rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, ovl = 1'b0, ot = 1'b0;
  logic cool = 1'b0, hold_low = 1'b1, p1 = 1'b1, p2 = 1'b1, swp, hready, hresp;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd, seed = 32'h49b5;
  logic [1:0] htrans = 2'h0;
  logic [3:0] ofault = 4'h0, son;
  logic [4:0] mc, sc, v1, v2, p;
  logic low_iq, r1, r2, cp, crun, den;
  int fails = 0, cmp_count = 0, n;
  always #5 clk = ~clk;
  logic hready_o;
  assign hready = hready_o;
  blf_host_model host_u (.clk(clk), .hold_low(hold_low), .single_wire_pin(swp));
  blf_backlight_ctrl #(.SHUTDOWN_US(1), .STARTUP_US(1), .FADE_TICK_US(1)) dut_u (
    .clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
    .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hreadyout(hready_o), .hrdata(hrdata),
    .hresp(hresp), .single_wire_pin(swp), .regulator_one_enable_pin(p1),
    .regulator_two_enable_pin(p2), .output_overvoltage_limit(ovl), .overtemp_shutdown(ot),
    .overtemp_cooled(cool), .open_fault(ofault), .main_code(mc), .sub_code(sc),
    .sink_on(son), .low_iq_bias(low_iq), .regulator_one_on(r1), .regulator_two_on(r2),
    .regulator_one_vsel(v1), .regulator_two_vsel(v2), .cp_switch_en(cp), .clk_run(crun),
    .device_enabled(den));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic report_and_stop;
    if (fails == 0 && cmp_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : report_and_stop

  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp)
    begin
      fails++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
  endfunction : lfsr

  // Expected ladder code: writes beyond full scale land on the top step
  function automatic logic [4:0] exp_lvl(input logic [4:0] v);
    return (v > 5'h1c) ? 5'h1c : v;
  endfunction : exp_lvl

  // One single AHB-Lite transfer; called just after a rising edge
  task automatic bus(input logic wr, input logic [3:0] idx, input logic [31:0] wd);
    hsel <= 1'b1;
    haddr <= {26'h0, idx, 2'b00};
    hwrite <= wr;
    htrans <= HTRANS_NONSEQ;
    do @(posedge clk); while (hready !== 1'b1);
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask : bus

  task automatic wr(input logic [3:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd);
    repeat (2) @(posedge clk);
  endtask : wr

  task automatic wt(input int c);
    repeat (c) @(posedge clk);
  endtask : wt

  // Follows a fade and flags any jump bigger than one ladder position
  task automatic fade_to(input logic [4:0] tgt, input bit on_sub, input int lim);
    logic [4:0] prev, cur;
    prev = on_sub ? sc : mc;
    cur = prev;
    for (int k = 0; k < lim && cur !== tgt; k++)
    begin
      @(posedge clk);
      cur = on_sub ? sc : mc;
      if (cur !== prev)
        chk("fade step", 32'(cur > prev ? cur - prev : prev - cur), 32'h1);
      prev = cur;
    end
    chk("fade end", 32'(cur), 32'(tgt));
  endtask : fade_to

  task automatic gap;
    p = mc;
    n = 0;
    do begin @(posedge clk); n++; end while (mc === p && n < 2000);
  endtask : gap

  task automatic start_up;
    hold_low <= 1'b0;
    n = 0;
    do begin @(posedge clk); n++; end while (den !== 1'b1 && n < 400);
    chk("startup delay", 32'(n > TICK), 32'h1);
    chk("enabled", 32'(den), 32'h1);
  endtask : start_up
  ////////////////////////////////////////////////////////////////////////////////
  initial
  begin
    wt(80000);
    fails++;
    report_and_stop();
  end

  initial
  begin
    logic [4:0] lvt [4];
    wt(3);
    rst <= 1'b0;
    @(posedge clk);
    chk("reset codes", 32'({sc, mc, son, low_iq, r1, r2, den, hresp}), 32'h10);
    start_up();
    chk("sleep clock", 32'(crun), 32'h0);
    chk("reg1 before setup", 32'(r1), 32'h0);
    bus(1'b0, IDX_STAT, 32'h0);
    chk("idle status", rd, 32'h13);
    wr(IDX_REG1, 32'h2a);
    wr(IDX_REG2, 32'h23);
    wt(2);
    chk("reg on in sleep", 32'({r1, r2, v1, v2}), 32'hd43);
    for (int i = 0; i < 4; i++)
    begin
      {p1, p2} <= 2'(i);
      wt(3);
      chk("reg gating", 32'({r1, r2}), 32'(i));
    end
    wr(IDX_EN, 32'hf);
    seed = lfsr(seed);
    lvt = '{5'h08, 5'h09, 5'h1f, 5'(seed % 28) + 5'h01};
    foreach (lvt[i])
    begin
      wr(IDX_MAIN, 32'(lvt[i]));
      chk("immediate level", 32'(mc), 32'(exp_lvl(lvt[i])));
      chk("zero sub off", 32'(son), 32'h7);
      chk("low iq", 32'(low_iq), 32'(lvt[i] <= LOWIQ_CODE));
    end
    wr(IDX_SUB, 32'h05);
    chk("sinks on", 32'({crun, son}), 32'h1f);
    ovl <= 1'b1;
    wt(3);
    chk("pump stop", 32'(cp), 32'h0);
    ovl <= 1'b0;
    wt(3);
    chk("pump resume", 32'(cp), 32'h1);
    // Fading at the fastest rate, down, up and on the sub group
    wr(IDX_FADE, 32'h20);
    wr(IDX_MAIN, 32'h00);
    fade_to(5'h00, 1'b0, 4000);
    wr(IDX_MAIN, 32'h1c);
    fade_to(5'h1c, 1'b0, 4000);
    wr(IDX_SUB, 32'h14);
    fade_to(5'h14, 1'b1, 4000);
    // Step spacing follows the rate, also when it changes mid-fade
    wr(IDX_MAIN, 32'h00);
    gap();
    gap();
    chk("step period", 32'(n), 32'(TICK));
    wr(IDX_FADE, 32'h22);
    gap();
    gap();
    chk("new rate period", 32'(n), 32'(3 * TICK));
    wr(IDX_MAIN, 32'h1c);
    p = mc;
    gap();
    chk("retarget from present", 32'(mc), 32'(p + 5'h01));
    fade_to(5'h1c, 1'b0, 9000);
    wr(IDX_MAIN, 32'h00);
    gap();
    wr(IDX_FADE, 32'h02);
    chk("abort to target", 32'(mc), 32'h0);
    wr(IDX_MAIN, 32'h0c);
    ot <= 1'b1;
    wt(3);
    chk("overtemp off", 32'({son, r1, r2, cp}), 32'h0);
    ot <= 1'b0;
    wt(3);
    chk("still hot", 32'(son), 32'h0);
    bus(1'b0, IDX_STAT, 32'h0);
    chk("hot status", rd, 32'h05);
    cool <= 1'b1;
    wt(3);
    chk("cooled", 32'({son, r1}), 32'h1f);
    cool <= 1'b0;
    bus(1'b0, IDX_MAIN, 32'h0);
    chk("kept level", rd, 32'h0c);
    ofault <= 4'h2;
    wt(3);
    chk("open sink off", 32'(son), 32'hd);
    ofault <= 4'h0;
    wr(IDX_FAULT, 32'hf);
    wt(2);
    chk("fault cleared", 32'(son), 32'hf);
    bus(1'b0, 4'hf, 32'h0);
    chk("unmapped read", {rd[30:0], hresp}, 32'h0);
    hold_low <= 1'b1;
    wt(TICK + 5);
    chk("shutdown", 32'(den), 32'h0);
    start_up();
    bus(1'b0, IDX_MAIN, 32'h0);
    chk("main default", rd, 32'h0);
    bus(1'b0, IDX_REG1, 32'h0);
    chk("reg1 default", {rd[30:0], r1}, 32'h0);
    report_and_stop();
  end
endmodule : backlight_fade_power_control_tb
`default_nettype wire
